// File: inc/tfdc_pkg.sv
`default_nettype none
package tfdc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] TFDC_FLOOR_ADDR = 8'h21;
	localparam logic [7:0] TFDC_LOCAL_ADDR = 8'h24;
	localparam logic [7:0] TFDC_REMOTE_ADDR = 8'h25;
	localparam logic [7:0] TFDC_LDUTY_ADDR = 8'h30;
	localparam logic [7:0] TFDC_RDUTY_ADDR = 8'h31;
	localparam logic [7:0] TFDC_FLOOR_RST = 8'h55;
	localparam logic [7:0] TFDC_LOCAL_RST = 8'h41;
	localparam logic [7:0] TFDC_REMOTE_RST = 8'h61;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int TFDC_THR_MSB = 7;
	localparam int TFDC_THR_LSB = 3;
	localparam int TFDC_SLP_MSB = 2;
	localparam int TFDC_DEG_PER_CODE_LOG2 = 2; // 4 degrees per step
	localparam logic [7:0] TFDC_DUTY_MAX = 8'hff;
endpackage
`default_nettype wire

// File: design/tfdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tfdc_top (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] local_temp_in,
	input wire logic [7:0] remote_temp_in,
	output logic [7:0] rdata_out,
	output logic [7:0] local_duty_out,
	output logic [7:0] remote_duty_out
);
	import tfdc_pkg::*;

	logic [7:0] floor_q, floor_d;
	logic [7:0] local_q, local_d;
	logic [7:0] remote_q, remote_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] lduty_q, lduty_d;
	logic [7:0] rduty_q, rduty_d;

	// ------------------------------------------------------------
	// duty law: floor below threshold, linear rise, saturation
	// ------------------------------------------------------------
	function automatic logic [7:0] duty_law(input logic [7:0] temp,
		input logic [7:0] ctl, input logic [7:0] floor);
		logic [7:0] thr;
		logic [8:0] excess;
		logic [17:0] sum;
		logic [5:0] slope;
		thr = {1'b0, ctl[TFDC_THR_MSB:TFDC_THR_LSB], 2'b00};
		excess = {1'b0, temp} - {1'b0, thr};
		case (ctl[TFDC_SLP_MSB:0])
			3'h0: slope = 6'h20;
			3'h1: slope = 6'h10;
			3'h2: slope = 6'h08;
			3'h3: slope = 6'h04;
			default: slope = 6'h02;
		endcase
		if (temp <= thr) begin
			duty_law = floor;
		end else begin
			// widen both factors first so the product cannot wrap
			sum = {10'h000, floor} +
				({10'h000, excess[7:0]} * {12'h000, slope});
			if (sum > 18'(TFDC_DUTY_MAX)) begin
				duty_law = TFDC_DUTY_MAX;
			end else begin
				duty_law = sum[7:0];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// register writes, read mux and duty computation
	// ------------------------------------------------------------
	always_comb begin
		floor_d = floor_q;
		local_d = local_q;
		remote_d = remote_q;
		if (wr_in) begin
			case (addr_in)
				TFDC_FLOOR_ADDR: floor_d = wdata_in;
				TFDC_LOCAL_ADDR: local_d = wdata_in;
				TFDC_REMOTE_ADDR: remote_d = wdata_in;
				default: ;
			endcase
		end
		rdata_d = 8'h00;
		if (rd_in) begin
			case (addr_in)
				TFDC_FLOOR_ADDR: rdata_d = floor_q;
				TFDC_LOCAL_ADDR: rdata_d = local_q;
				TFDC_REMOTE_ADDR: rdata_d = remote_q;
				TFDC_LDUTY_ADDR: rdata_d = lduty_q;
				TFDC_RDUTY_ADDR: rdata_d = rduty_q;
				default: rdata_d = 8'h00;
			endcase
		end
		lduty_d = duty_law(local_temp_in, local_q, floor_q);
		rduty_d = duty_law(remote_temp_in, remote_q, floor_q);
	end

	// registers with reset values
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			floor_q <= TFDC_FLOOR_RST;
			local_q <= TFDC_LOCAL_RST;
			remote_q <= TFDC_REMOTE_RST;
			rdata_q <= 8'h00;
			lduty_q <= TFDC_FLOOR_RST;
			rduty_q <= TFDC_FLOOR_RST;
		end else begin
			floor_q <= floor_d;
			local_q <= local_d;
			remote_q <= remote_d;
			rdata_q <= rdata_d;
			lduty_q <= lduty_d;
			rduty_q <= rduty_d;
		end
	end

	assign rdata_out = rdata_q;
	assign local_duty_out = lduty_q;
	assign remote_duty_out = rduty_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_local_floor;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(local_temp_in <= {1'b0, local_q[7:3], 2'b00})
			|=> (lduty_q == $past(floor_q));
	endproperty
	a_local_floor: assert property (p_local_floor)
		else $error("local duty not at floor");

	property p_remote_floor;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(remote_temp_in <= {1'b0, remote_q[7:3], 2'b00})
			|=> (rduty_q == $past(floor_q));
	endproperty
	a_remote_floor: assert property (p_remote_floor)
		else $error("remote duty not at floor");

	property p_local_slope16;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(local_q[2:0] == 3'h1 && floor_q == 8'h00 &&
			local_temp_in == {1'b0, local_q[7:3], 2'b00} + 8'h01)
			|=> (lduty_q == 8'h10);
	endproperty
	a_local_slope16: assert property (p_local_slope16)
		else $error("local slope wrong");

	property p_remote_slope2;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(remote_q[2:0] == 3'h4 && floor_q == 8'h00 &&
			remote_temp_in == {1'b0, remote_q[7:3], 2'b00} + 8'h03)
			|=> (rduty_q == 8'h06);
	endproperty
	a_remote_slope2: assert property (p_remote_slope2)
		else $error("remote slope wrong");

	property p_local_write;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_in && addr_in == TFDC_LOCAL_ADDR)
			|=> (local_q == $past(wdata_in));
	endproperty
	a_local_write: assert property (p_local_write)
		else $error("local register write lost");

	property p_remote_write;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_in && addr_in == TFDC_REMOTE_ADDR)
			|=> (remote_q == $past(wdata_in));
	endproperty
	a_remote_write: assert property (p_remote_write)
		else $error("remote register write lost");

	property p_floor_read;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(rd_in && addr_in == TFDC_FLOOR_ADDR && !wr_in)
			|=> (rdata_out == $past(floor_q));
	endproperty
	a_floor_read: assert property (p_floor_read)
		else $error("floor readback wrong");

	property p_saturate;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(local_q[2:0] == 3'h0 && floor_q == 8'hf0 &&
			local_temp_in == {1'b0, local_q[7:3], 2'b00} + 8'h01)
			|=> (lduty_q == TFDC_DUTY_MAX);
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("duty did not saturate");

	// further points of the duty law and of register access
	property p_local_slope32;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(local_q[2:0] == 3'h0 && floor_q == 8'h55 &&
			local_temp_in == {1'b0, local_q[7:3], 2'b00} + 8'h01)
			|=> (lduty_q == 8'h75);
	endproperty
	a_local_slope32: assert property (p_local_slope32)
		else $error("local slope32 wrong");

	property p_remote_slope8;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(remote_q[2:0] == 3'h2 && floor_q == 8'hc0 &&
			remote_temp_in == {1'b0, remote_q[7:3], 2'b00} + 8'h03)
			|=> (rduty_q == 8'hd8);
	endproperty
	a_remote_slope8: assert property (p_remote_slope8)
		else $error("remote slope8 wrong");

	property p_remote_saturate;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(remote_q[2:0] == 3'h0 && floor_q == 8'hf0 &&
			remote_temp_in == {1'b0, remote_q[7:3], 2'b00} + 8'h01)
			|=> (rduty_q == TFDC_DUTY_MAX);
	endproperty
	a_remote_saturate: assert property (p_remote_saturate)
		else $error("remote duty did not saturate");

	property p_floor_write;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(wr_in && addr_in == TFDC_FLOOR_ADDR)
			|=> (floor_q == $past(wdata_in));
	endproperty
	a_floor_write: assert property (p_floor_write)
		else $error("floor register write lost");

	property p_local_read;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(rd_in && addr_in == TFDC_LOCAL_ADDR && !wr_in)
			|=> (rdata_out == $past(local_q));
	endproperty
	a_local_read: assert property (p_local_read)
		else $error("local readback wrong");

	property p_reset_vals;
		@(posedge clk_sys_in)
		$rose(nrst_in) |-> (local_q == TFDC_LOCAL_RST &&
			remote_q == TFDC_REMOTE_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tfdc_pkg::*;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] local_temp_in = 8'h00;
	logic [7:0] remote_temp_in = 8'h00;
	logic [7:0] rdata_out;
	logic [7:0] local_duty_out;
	logic [7:0] remote_duty_out;
	int miscompares = 0;
	int samples_checked = 0;
	int offs[5] = '{-1, 0, 1, 3, 9};
	// 250 MHz system clock
	always #2 clk_sys_in = ~clk_sys_in;
	tfdc_top u_tfdc_top (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.local_temp_in(local_temp_in), .remote_temp_in(remote_temp_in),
		.rdata_out(rdata_out), .local_duty_out(local_duty_out),
		.remote_duty_out(remote_duty_out)
	);
	// -------------------------------------------------------------
	// shared tasks
	// -------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one write cycle, then an idle edge before the next strobe
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
		@(posedge clk_sys_in);
	endtask
	// floor plus slope per degree above threshold, clamped to full scale
	function automatic logic [7:0] exp_duty(input logic [7:0] fl,
			input logic [2:0] s, input int ex);
		int v;
		// codes above four keep the shallowest slope of 2 per degree
		v = (ex <= 0) ? fl : fl + (((s > 3'h4) ? 2 : (32 >> s)) * ex);
		return (v > 255) ? 8'hff : v[7:0];
	endfunction
	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic test_reset();
		logic [7:0] d;
		// look at the duty outputs away from the edge that updates them
		@(negedge clk_sys_in);
		check(local_duty_out, TFDC_FLOOR_RST);
		check(remote_duty_out, TFDC_FLOOR_RST);
		@(posedge clk_sys_in);
		reg_rd(TFDC_FLOOR_ADDR, d);
		check(d, 8'h55);
		reg_rd(TFDC_LOCAL_ADDR, d);
		check(d, 8'h41);
		reg_rd(TFDC_REMOTE_ADDR, d);
		check(d, 8'h61);
		reg_rd(8'h3f, d);
		check(d, 8'h00);
	endtask
	// sweeps every slope code and temperatures around the threshold
	task automatic test_loop(input bit rem, input logic [7:0] fl);
		logic [7:0] ctl;
		logic [7:0] d;
		int thr;
		reg_wr(TFDC_FLOOR_ADDR, fl);
		for (int c = 0; c < 8; c++) begin
			ctl = {5'(c * 4 + 2), 3'(c)};
			thr = (c * 4 + 2) * 4;
			reg_wr(rem ? TFDC_REMOTE_ADDR : TFDC_LOCAL_ADDR, ctl);
			reg_rd(rem ? TFDC_REMOTE_ADDR : TFDC_LOCAL_ADDR, d);
			check(d, ctl);
			foreach (offs[i]) begin
				local_temp_in <= 8'(thr + offs[i]);
				remote_temp_in <= 8'(thr + offs[i]);
				repeat (2) @(posedge clk_sys_in);
				#1 d = rem ? remote_duty_out : local_duty_out;
				check(d, exp_duty(fl, 3'(c), offs[i]));
				@(posedge clk_sys_in);
				reg_rd(rem ? TFDC_RDUTY_ADDR : TFDC_LDUTY_ADDR, d);
				check(d, exp_duty(fl, 3'(c), offs[i]));
			end
		end
	endtask
	// reset in mid-run must bring every register back to its reset value
	task automatic test_midreset();
		reg_wr(TFDC_LOCAL_ADDR, 8'h12);
		reg_wr(TFDC_REMOTE_ADDR, 8'h34);
		reg_wr(TFDC_FLOOR_ADDR, 8'h99);
		local_temp_in <= 8'h00;
		remote_temp_in <= 8'h00;
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		test_reset();
	endtask
	// -------------------------------------------------------------
	// main sequence and watchdog
	// -------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		test_reset();
		test_loop(1'b0, 8'h55);
		test_loop(1'b1, 8'hc0);
		test_loop(1'b0, 8'h00);
		test_loop(1'b1, 8'h00);
		test_loop(1'b0, 8'hf0);
		test_loop(1'b1, 8'hf0);
		test_midreset();
		finish_test();
	end
	initial begin
		#20000;
		miscompares++;
		finish_test();
	end
endmodule
`default_nettype wire
